/* File: design/pcm_clock_ctrl.v */
`timescale 1ns/1ns
`include "pcm_map.vh"

module pcm_clock_ctrl (
   input wire CLK_SYS,
   input wire RST,
   input wire CE,
   input wire REF_CLOCK_IN,
   input wire PLL_CLOCK_IN,
   input wire [15:0] MEM_ADDR,
   input wire MEM_WR,
   input wire MEM_RD,
   input wire MEM_SUBSYS_B,
   input wire [15:0] MEM_WDATA,
   output reg [15:0] MEM_RDATA,
   output reg CORE_CLOCK_OUT,
   output wire VCO_ENABLE,
   output reg [4:0] MULT_NUM,
   output reg [2:0] MULT_DEN,
   output wire MODE_INDICATOR,
   output wire LOCK_BUSY
);

   // Mode sequencer states.
   localparam ST_DIV = 2'b00;
   localparam ST_LOCK = 2'b01;
   localparam ST_SWAP = 2'b10;
   localparam ST_PLL = 2'b11;

   // Core clock sources.
   localparam SRC_DIV = 2'b00;
   localparam SRC_PLL = 2'b01;
   localparam SRC_REF = 2'b10;

   reg [3:0] mult_q;
   reg frac_q;
   reg [7:0] cnt_q;
   reg vco_on_q;
   reg ndiv_q;
   reg div4_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [7:0] lock_q;
   reg [3:0] pre_q;
   reg ref_q;
   reg ref_prev_q;
   reg pll_q;
   reg [1:0] div_cnt_q;
   reg [1:0] src_q;
   reg [1:0] des_src;
   reg cur_lvl;
   reg des_lvl;
   reg [4:0] num_d;
   reg [2:0] den_d;

   wire hit;
   wire wr_hit;
   wire rd_hit;
   wire go_pll;
   wire go_div;
   wire ref_rise;
   wire bypass;
   wire safe;
   wire [15:0] image;

   // Subsystem B is decoded as a miss, so it never sees or moves the
   // clock configuration.
   assign hit = (MEM_ADDR == `PCM_CLKMODE_ADDR) && !MEM_SUBSYS_B;
   assign wr_hit = CE && MEM_WR && hit;
   assign rd_hit = CE && MEM_RD && hit;

   // A write that raises the mode bit from divide starts the lock timer;
   // a write that clears it returns to divide at once.
   assign go_pll = wr_hit && MEM_WDATA[`PCM_F_NDIV] && !ndiv_q;
   assign go_div = wr_hit && !MEM_WDATA[`PCM_F_NDIV];

   assign ref_rise = ref_q && !ref_prev_q;

   // Multiplier field 15 with integer select is a straight pass of the
   // reference clock and needs no locked VCO output.
   assign bypass = (mult_q == `PCM_MULT_MAX) && !frac_q;

   // The VCO may only stop when both control bits are clear.
   assign VCO_ENABLE = vco_on_q | ndiv_q;

   assign MODE_INDICATOR = (state_q == ST_PLL);
   assign LOCK_BUSY = (state_q == ST_LOCK);

   // Readback image; fields other than the mode bits are held as written
   // even in divide mode, which software must treat as don't-care.
   assign image = {mult_q, frac_q, cnt_q, vco_on_q, ndiv_q,
                   MODE_INDICATOR};

   // Reference and VCO levels are sampled once; the inputs are taken as
   // synchronous, so a single stage is enough.
   always @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         ref_q <= 1'b0;
         ref_prev_q <= 1'b0;
         pll_q <= 1'b0;
      end
      else if (CE)
      begin
         ref_q <= REF_CLOCK_IN;
         ref_prev_q <= ref_q;
         pll_q <= PLL_CLOCK_IN;
      end
   end

   // Free-running divider on reference edges: bit 0 is ref/2, bit 1 ref/4.
   always @(posedge CLK_SYS)
   begin
      if (RST)
         div_cnt_q <= 2'b00;
      else if (CE && ref_rise)
         div_cnt_q <= div_cnt_q + 2'b01;
   end

   // Register fields. The status bit is not stored: it is the sequencer.
   always @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         mult_q <= `PCM_MULT_RST;
         frac_q <= 1'b0;
         cnt_q <= `PCM_CNT_RST;
         vco_on_q <= 1'b0;
         ndiv_q <= 1'b1;
         div4_q <= 1'b0;
      end
      else if (wr_hit)
      begin
         mult_q <= MEM_WDATA[`PCM_F_MULT_HI:`PCM_F_MULT_LO];
         frac_q <= MEM_WDATA[`PCM_F_FRAC];
         cnt_q <= MEM_WDATA[`PCM_F_CNT_HI:`PCM_F_CNT_LO];
         vco_on_q <= MEM_WDATA[`PCM_F_VCO];
         ndiv_q <= MEM_WDATA[`PCM_F_NDIV];
         // The divide ratio is fixed by the write that selects divide
         // mode, so a later PLL setup does not disturb it while locking.
         if (!MEM_WDATA[`PCM_F_NDIV])
            div4_q <= (MEM_WDATA[`PCM_F_MULT_HI:`PCM_F_MULT_LO] ==
                       `PCM_MULT_MAX);
      end
   end

   // Read data is registered and answers zero to any miss.
   always @(posedge CLK_SYS)
   begin
      if (RST)
         MEM_RDATA <= 16'h0000;
      else if (CE && MEM_RD)
         MEM_RDATA <= rd_hit ? image : 16'h0000;
   end

   // Ratio decode: numerator over a denominator of 1, 2 or 4.
   always @*
   begin
      num_d = 5'h01;
      den_d = `PCM_DEN_1;
      if (!ndiv_q)
      begin
         num_d = 5'h01;
         den_d = (mult_q == `PCM_MULT_MAX) ? `PCM_DEN_4 : `PCM_DEN_2;
      end
      else if (!frac_q)
      begin
         // Field 15 gives bypass, times one.
         num_d = (mult_q == `PCM_MULT_MAX) ? 5'h01 :
                 ({1'b0, mult_q} + 5'h01);
         den_d = `PCM_DEN_1;
      end
      else if (mult_q[0])
      begin
         num_d = {1'b0, mult_q};
         den_d = `PCM_DEN_4;
      end
      else
      begin
         num_d = {1'b0, mult_q} + 5'h01;
         den_d = `PCM_DEN_2;
      end
   end

   // Ratio outputs to the analog loop.
   always @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         MULT_NUM <= 5'h01;
         MULT_DEN <= `PCM_DEN_1;
      end
      else if (CE)
      begin
         MULT_NUM <= num_d;
         MULT_DEN <= den_d;
      end
   end

   // Sequencer: divide, lock wait, clean swap, PLL.
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_DIV:
            if (go_pll)
               state_d = ST_LOCK;
         ST_LOCK:
            if (go_div)
               state_d = ST_DIV;
            else if (lock_q == 8'h00)
               state_d = ST_SWAP;
         ST_SWAP:
            if (go_div)
               state_d = ST_DIV;
            else if (src_q == des_src)
               state_d = ST_PLL;
         ST_PLL:
            if (go_div)
               state_d = ST_DIV;
         default:
            state_d = ST_DIV;
      endcase
   end

   // Reset lands directly in bypass PLL mode, with no lock wait.
   always @(posedge CLK_SYS)
   begin
      if (RST)
         state_q <= ST_PLL;
      else if (CE)
         state_q <= state_d;
   end

   // Lock timer: loaded on the switch request, one decrement per sixteen
   // reference edges. A load of zero expires on the next cycle.
   always @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         lock_q <= 8'h00;
         pre_q <= 4'h0;
      end
      else if (CE)
      begin
         if (go_pll && state_q == ST_DIV)
         begin
            lock_q <= MEM_WDATA[`PCM_F_CNT_HI:`PCM_F_CNT_LO];
            pre_q <= 4'h0;
         end
         else if (state_q == ST_LOCK && ref_rise && lock_q != 8'h00)
         begin
            pre_q <= pre_q + 4'h1;
            if (pre_q == `PCM_PRE_LAST)
               lock_q <= lock_q - 8'h01;
         end
      end
   end

   // Wanted source: the divider until the swap, then PLL or reference.
   always @*
   begin
      if (state_q == ST_SWAP || state_q == ST_PLL)
         des_src = bypass ? SRC_REF : SRC_PLL;
      else
         des_src = SRC_DIV;
   end

   // Levels of the present and wanted sources.
   always @*
   begin
      case (src_q)
         SRC_PLL: cur_lvl = pll_q;
         SRC_REF: cur_lvl = ref_q;
         default: cur_lvl = div4_q ? div_cnt_q[1] : div_cnt_q[0];
      endcase
      case (des_src)
         SRC_PLL: des_lvl = pll_q;
         SRC_REF: des_lvl = ref_q;
         default: des_lvl = div4_q ? div_cnt_q[1] : div_cnt_q[0];
      endcase
   end

   // Switching only while both sources are low means the output never
   // shows a cut high or low phase; the cost is a wait of up to one
   // period of the slower source.
   assign safe = !cur_lvl && !des_lvl;

   // Source select and core clock output.
   always @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         src_q <= SRC_REF;
         CORE_CLOCK_OUT <= 1'b0;
      end
      else if (CE)
      begin
         if (src_q != des_src && safe)
         begin
            src_q <= des_src;
            CORE_CLOCK_OUT <= 1'b0;
         end
         else
            CORE_CLOCK_OUT <= cur_lvl;
      end
   end

endmodule // pcm_clock_ctrl

/* File: design/pcm_map.vh */
`ifndef PCM_MAP_VH
`define PCM_MAP_VH

// Register address and reset image.
`define PCM_CLKMODE_ADDR 16'h0058
`define PCM_CLKMODE_RST 16'hF003

// Field positions.
`define PCM_F_MULT_HI 15
`define PCM_F_MULT_LO 12
`define PCM_F_FRAC 11
`define PCM_F_CNT_HI 10
`define PCM_F_CNT_LO 3
`define PCM_F_VCO 2
`define PCM_F_NDIV 1
`define PCM_F_STAT 0

// Field reset values and the multiplier maximum.
`define PCM_MULT_RST 4'hF
`define PCM_MULT_MAX 4'hF
`define PCM_CNT_RST 8'h00

// Lock timer prescale: one tick per 16 reference edges.
`define PCM_PRE_LAST 4'hF

// Multiplier denominators.
`define PCM_DEN_1 3'h1
`define PCM_DEN_2 3'h2
`define PCM_DEN_4 3'h4

`endif

/* File: dv/pcm_clk_src.sv */
`timescale 1ns/1ns
// The reference runs free at a quarter of the system rate. The VCO output
// stands low while the VCO is off, as a stopped oscillator would.
module pcm_clk_src (
   input wire clk,
   input wire vco_on,
   output reg ref_clk = 1'b0,
   output reg pll_clk = 1'b0
);
   reg [1:0] ph_q = 2'h0;
   // Both sources advance on the system clock.
   always @(posedge clk)
   begin
      ph_q <= ph_q + 2'h1;
      ref_clk <= ph_q[1];
      // An unknown enable before reset must not lock the VCO model at X.
      if (vco_on === 1'b1)
         pll_clk <= ~pll_clk;
      else
         pll_clk <= 1'b0;
   end
endmodule // pcm_clk_src

/* File: dv/pcm_clock_ctrl_properties.sv */
`timescale 1ns/1ns
module pcm_clock_ctrl_props (
   input wire CLK_SYS, RST, CE, REF_CLOCK_IN, PLL_CLOCK_IN,
   input wire [15:0] MEM_ADDR,
   input wire MEM_WR, MEM_RD, MEM_SUBSYS_B,
   input wire [15:0] MEM_WDATA, MEM_RDATA,
   input wire CORE_CLOCK_OUT, VCO_ENABLE,
   input wire [4:0] MULT_NUM,
   input wire [2:0] MULT_DEN,
   input wire MODE_INDICATOR, LOCK_BUSY
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   reg [15:0] wd1_q, wd2_q;
   reg mode_q;
   // Write data is delayed so results can be tied back to their cause.
   always @(posedge CLK_SYS)
   begin
      wd1_q <= MEM_WDATA;
      wd2_q <= wd1_q;
   end
   wire hit = CE && !MEM_SUBSYS_B && MEM_ADDR == 16'h0058;
   // Last mode bit taken by the register; reset leaves PLL mode selected.
   always @(posedge CLK_SYS)
   begin
      if (RST)
         mode_q <= 1'b1;
      else if (hit && MEM_WR)
         mode_q <= MEM_WDATA[1];
   end
   sequence s_wr; hit && MEM_WR; endsequence
   sequence s_div; s_wr ##0 !MEM_WDATA[1]; endsequence
   property p_vco; s_wr |=> VCO_ENABLE == (wd1_q[2] | wd1_q[1]); endproperty
   a_vco: assert property (p_vco) else $error("vco state");
   property p_div; s_div ##1 (CE && !MEM_WR) |=> MULT_NUM == 5'h01 &&
      MULT_DEN == (wd2_q[15:12] == 4'hF ? 3'h4 : 3'h2); endproperty
   a_div: assert property (p_div) else $error("divide ratio");
   property p_drop; s_div |=> !MODE_INDICATOR; endproperty
   a_drop: assert property (p_drop) else $error("status stays");
   property p_arm; s_wr ##0 (MEM_WDATA[1] && !mode_q) |=> LOCK_BUSY;
   endproperty
   a_arm: assert property (p_arm) else $error("timer idle");
   property p_excl; !(MODE_INDICATOR && LOCK_BUSY); endproperty
   a_excl: assert property (p_excl) else $error("pll while locking");
   property p_miss; CE && MEM_RD && (MEM_SUBSYS_B || MEM_ADDR != 16'h0058)
      |=> MEM_RDATA == 16'h0000; endproperty
   a_miss: assert property (p_miss) else $error("miss read data");
   property p_hold; !(CE && MEM_RD) |=> $stable(MEM_RDATA); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_stat; hit && MEM_RD |=> MEM_RDATA[0] == $past(MODE_INDICATOR);
   endproperty
   a_stat: assert property (p_stat) else $error("status bit");
   property p_rst; $fell(RST) |-> MODE_INDICATOR && !LOCK_BUSY &&
      MULT_NUM == 5'h01 && MULT_DEN == 3'h1; endproperty
   a_rst: assert property (p_rst) else $error("reset mode");
endmodule // pcm_clock_ctrl_props
bind pcm_clock_ctrl pcm_clock_ctrl_props u_props (.CLK_SYS(CLK_SYS),
   .RST(RST), .CE(CE), .REF_CLOCK_IN(REF_CLOCK_IN),
   .PLL_CLOCK_IN(PLL_CLOCK_IN), .MEM_ADDR(MEM_ADDR), .MEM_WR(MEM_WR),
   .MEM_RD(MEM_RD), .MEM_SUBSYS_B(MEM_SUBSYS_B), .MEM_WDATA(MEM_WDATA),
   .MEM_RDATA(MEM_RDATA), .CORE_CLOCK_OUT(CORE_CLOCK_OUT),
   .VCO_ENABLE(VCO_ENABLE), .MULT_NUM(MULT_NUM), .MULT_DEN(MULT_DEN),
   .MODE_INDICATOR(MODE_INDICATOR), .LOCK_BUSY(LOCK_BUSY));

/* File: dv/tb.sv */
`timescale 1ns/1ns
module tb;
   reg clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, sb = 1'b0;
   reg [15:0] addr = 16'h0000, wd = 16'h0000, d;
   wire [15:0] rdata;
   wire refc, pllc, cko, vco, mi, lb;
   wire [4:0] num;
   wire [2:0] den;
   integer errors = 0, cmp_count = 0, cyc = 0, i, n, c, p;
   pcm_clk_src src (.clk(clk), .vco_on(vco), .ref_clk(refc), .pll_clk(pllc));
   pcm_clock_ctrl uut (.CLK_SYS(clk), .RST(rst), .CE(ce),
      .REF_CLOCK_IN(refc), .PLL_CLOCK_IN(pllc), .MEM_ADDR(addr),
      .MEM_WR(wr), .MEM_RD(rd), .MEM_SUBSYS_B(sb), .MEM_WDATA(wd),
      .MEM_RDATA(rdata), .CORE_CLOCK_OUT(cko), .VCO_ENABLE(vco),
      .MULT_NUM(num), .MULT_DEN(den), .MODE_INDICATOR(mi),
      .LOCK_BUSY(lb));
   // A 4 ns period gives the 250 MHz system rate.
   always #2 clk = ~clk;
   task tally_and_finish;
      $display("Checks %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // A hang is cut short well beyond the longest lock wait.
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 40000)
      begin
         errors = errors + 1;
         tally_and_finish;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
         errors = errors + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One access cycle; strobes drop at the edge that takes them.
   task acc(input w, input b, input e, input [15:0] a, input [15:0] v);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      sb <= b;
      ce <= e;
      addr <= a;
      wd <= v;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      ce <= 1'b1;
   endtask
   // Core clock period in system cycles, measured from rise to rise.
   task per(output integer q);
      time t0;
      begin
         @(posedge cko);
         t0 = $time;
         @(posedge cko);
         q = ($time - t0) / 4;
      end
   endtask
   // Expected ratio as {numerator, denominator}, left unreduced.
   function [7:0] rat(input [15:0] v);
      reg [4:0] m;
      begin
         m = {1'b0, v[15:12]};
         if (!v[1])
            rat = {5'h01, m == 5'h0F ? 3'h4 : 3'h2};
         else if (!v[11])
            rat = {m == 5'h0F ? 5'h01 : m + 5'h01, 3'h1};
         else if (!m[0])
            rat = {m + 5'h01, 3'h2};
         else
            rat = {m, 3'h4};
      end
   endfunction
   // Reset state first, then misses, then every ratio through a divide and a lock cycle.
   initial
   begin
      void'($urandom(16287));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      acc(0, 0, 1, 16'h0058, 16'h0000);
      #1 chk(rdata, 16'hF003);
      chk({num, den}, 8'h09);
      per(p);
      chk(p, 4);
      acc(1, 1, 1, 16'h0058, 16'h0000);
      acc(0, 1, 1, 16'h0058, 16'h0000);
      #1 chk(rdata, 16'h0000);
      acc(0, 0, 1, 16'h0059, 16'h0000);
      #1 chk(rdata, 16'h0000);
      acc(1, 0, 0, 16'h0058, 16'h0000);
      acc(0, 0, 1, 16'h0058, 16'h0000);
      #1 chk(rdata, 16'hF003);
      for (i = 0; i < 32; i = i + 1)
      begin
         c = (i == 31) ? 255 : $urandom_range(3);
         d = {i[3:0], i[4], c[7:0], 1'($urandom), 2'b00};
         acc(1, 0, 1, 16'h0058, d);
         @(posedge clk);
         #1 chk(mi, 0);
         chk(vco, d[2]);
         chk({num, den}, rat(d));
         acc(0, 0, 1, 16'h0058, 16'h0000);
         #1 chk(rdata[0], 0);
         // Leave time for the source to reach the divider at a safe point.
         repeat (20) @(posedge clk);
         per(p);
         chk(p, d[15:12] == 4'hF ? 16 : 8);
         d[1] = 1'b1;
         acc(1, 0, 1, 16'h0058, d);
         #1 chk(lb, 1);
         n = 0;
         while (mi !== 1'b1 && n < 20000)
         begin
            @(posedge clk);
            #1 n = n + 1;
         end
         chk(n >= c * 64 - 4 && n <= c * 64 + 40, 1);
         chk({num, den}, rat(d));
         per(p);
         chk(p, (d[15:12] == 4'hF && !d[11]) ? 4 : 2);
         acc(0, 0, 1, 16'h0058, 16'h0000);
         #1 chk(rdata, d | 16'h0001);
      end
      tally_and_finish;
   end
endmodule // tb
